/* bmrt_bus_model.sv */
`timescale 1ns/1ns
`default_nettype none
module bmrt_bus_model (
  input wire logic i_clk, // System clock
  output logic o_rx_valid, // Byte strobe
  output logic [7:0] o_rx_data, // Byte
  output logic o_rx_last // Checksum byte
);
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_last = 1'b0;
  end
  // Idle data is inverted on each of the four idle cycles after a message, so it equals the last byte again on every second one
  task automatic send(input logic [63:0] m, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk);
      #1;
      o_rx_valid = 1'b1;
      o_rx_data = m[8*(n-1-k) +: 8];
      o_rx_last = (k == n - 1);
    end
    repeat (4) begin
      @(posedge i_clk);
      #1;
      o_rx_valid = 1'b0;
      o_rx_last = 1'b0;
      o_rx_data = ~o_rx_data;
    end
  endtask
endmodule // bmrt_bus_model
`default_nettype wire

/* bmrt_filter.v */
`timescale 1ns/1ns
`default_nettype none
`include "bmrt_map.vh"

module bmrt_filter (
  input wire i_en,                             // Filter enabled
  input wire [39:0] i_pat,                     // Pattern, byte 0 in bits 7:0
  input wire [`BMRT_FLT_NIB-1:0] i_care,       // One bit per nibble, 1 = compare
  input wire [39:0] i_msg,                     // First five message bytes
  input wire [4:0] i_nbytes,                   // Data bytes held, checksum excluded
  output reg o_hit                             // Enabled and pattern matched
);

  integer k;
  reg ok;

  // Absent bytes only pass where the nibble is don't-care
  always @* begin
    ok = 1'b1;
    for (k = 0; k < `BMRT_FLT_NIB; k = k + 1) begin
      if (i_care[k] && (({27'h0, i_nbytes} <= (k / 2)) || (i_msg[k*4 +: 4] != i_pat[k*4 +: 4]))) begin
        ok = 1'b0;
      end
    end
    o_hit = i_en && ok;
  end

endmodule // bmrt_filter

`default_nettype wire

/* bmrt_map.vh */
`ifndef BMRT_MAP_VH
`define BMRT_MAP_VH

// Clock and reply timer
`define BMRT_CLK_MHZ 100
`define BMRT_TICK_MS 100
`define BMRT_TICK_CYC (`BMRT_TICK_MS * 1000 * `BMRT_CLK_MHZ)
`define BMRT_TICK_W 24
`define BMRT_ST_DEFAULT 8'h0F
`define BMRT_ST_MIN 8'h01

// Message store
`define BMRT_MSG_MAX 21
`define BMRT_MSG_LAST 5'h14
`define BMRT_FLT_NIB 10

// Host operations
`define BMRT_OP_GET_MANY 3'h0
`define BMRT_OP_GET_ONE 3'h1
`define BMRT_OP_MON_ALL 3'h2
`define BMRT_OP_MON_SRC 3'h3
`define BMRT_OP_MON_PID 3'h4

// Output item codes
`define BMRT_OUT_BYTE 3'h0
`define BMRT_OUT_DASH 3'h1
`define BMRT_OUT_EOL 3'h2
`define BMRT_OUT_NODATA 3'h3
`define BMRT_OUT_STOP 3'h4

// Parameter identifier classes
`define BMRT_PID_1B_HI 8'h1F
`define BMRT_PID_2B_LO 8'h80
`define BMRT_PID_2B_HI 8'hBF
`define BMRT_PID_PAGE2 8'hFF

`endif

/* bmrt_reply_timer.v */
// Overview of operation
// - After a request, wait for replies at most the timeout period, default 1.5 s.
// - Timeout with no reply ends waiting and reports an empty result.
// - After each reply keep waiting; the same timer ends collection.
// - Timeout set in 100 ms steps, from 0.1 s to 25.5 s.
// - Response-count digit 0 to F accepted only after raw hex bytes.
// - Once the counted responses are printed, return at once without timeout wait.
// - Get-one acts as a response limit of one.
// - Monitor-all shows every message until the host sends any character.
// - Monitor-by-source shows only messages whose first byte equals the given source.
// - With source display off, the leading source byte is not printed.
// - Checksum hidden by default; when enabled it ends each printed line.
// - Identifier 00 to 1F is followed by one data byte.
// - Identifier 80 to BF is followed by two data bytes.
// - First identifier FF: parse from third byte, all identifiers are page 2.
// - Monitor-by-parameter finds the identifier anywhere, prints source, it and its data.
// - With checksum on, a parameter line missing other content is marked partial.
// - Partial marker is a dash before the checksum, absent if nothing hidden.
// - Pattern filters compare the first five bytes, nibbles may be don't-care.
// - With neither pattern filter enabled every message passes.
`timescale 1ns/1ns
`default_nettype none
`include "bmrt_map.vh"

module bmrt_reply_timer #(
  parameter P_TICK_CYC = `BMRT_TICK_CYC
) (
  input wire i_clk,                         // System clock, 100 MHz
  input wire i_rst_n,                       // Synchronous reset, active low
  input wire i_cmd_valid,                   // Start an operation (pulse)
  input wire [2:0] i_cmd_op,                // Operation code
  input wire [7:0] i_cmd_mid,               // Source for monitor-by-source
  input wire [8:0] i_cmd_pid,               // Identifier, bit 8 = page 2
  input wire i_cmd_pid_en,                  // Get commands: filter by identifier
  input wire i_cmd_raw,                     // Command carried raw hex bytes
  input wire i_cmd_count_en,                // Response-count digit present
  input wire [3:0] i_cmd_count,             // Response-count digit
  input wire i_host_char,                   // Host sent a character (pulse)
  input wire [7:0] i_reply_timeout_setting, // Timeout in 100 ms units
  input wire i_source_display_off,          // Hide source byte
  input wire i_checksum_display_on,         // Show checksum byte
  input wire i_first_pattern_filter_en,     // First filter enable
  input wire [39:0] i_first_pattern_filter, // First filter pattern
  input wire [9:0] i_first_pattern_care,    // First filter nibble compare mask
  input wire i_second_pattern_filter_en,    // Second filter enable
  input wire [39:0] i_second_pattern_filter,// Second filter pattern
  input wire [9:0] i_second_pattern_care,   // Second filter nibble compare mask
  input wire i_rx_valid,                    // Received bus byte strobe
  input wire [7:0] i_rx_data,               // Received bus byte
  input wire i_rx_last,                     // Byte is the checksum ending a message
  input wire i_out_ready,                   // Host side takes an output item
  output reg o_out_valid,                   // Output item valid
  output reg [7:0] o_out_data,              // Output byte
  output reg [2:0] o_out_code,              // Output item kind
  output reg o_busy,                        // Operation in progress
  output reg o_done                         // Operation finished (pulse)
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_COLLECT = 3'h1;
  localparam [2:0] S_CHECK = 3'h2;
  localparam [2:0] S_SCAN = 3'h3;
  localparam [2:0] S_PRINT = 3'h4;
  localparam [2:0] S_FINISH = 3'h5;

  localparam [2:0] PH_MID = 3'h0;
  localparam [2:0] PH_HDR = 3'h1;
  localparam [2:0] PH_BODY = 3'h2;
  localparam [2:0] PH_DASH = 3'h3;
  localparam [2:0] PH_CSUM = 3'h4;
  localparam [2:0] PH_EOL = 3'h5;

  // Bytes that follow an identifier; variable ones carry a count byte
  function [8:0] pid_len;
    input [7:0] pid;
    input [7:0] nxt;
    begin
      if (pid <= `BMRT_PID_1B_HI) begin
        pid_len = 9'h001;
      end else if (pid < `BMRT_PID_2B_LO) begin
        pid_len = 9'h001;
      end else if (pid <= `BMRT_PID_2B_HI) begin
        pid_len = 9'h002;
      end else begin
        pid_len = {1'b0, nxt} + 9'h001;
      end
    end
  endfunction

  function [7:0] st_clamp;
    input [7:0] s;
    begin
      st_clamp = (s < `BMRT_ST_MIN) ? `BMRT_ST_MIN : s;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  reg [7:0] msg_q [0:`BMRT_MSG_MAX-1];
  reg [2:0] state_q;
  reg [2:0] op_q;
  reg [7:0] mid_q;
  reg [7:0] pid_q;
  reg pg2_req_q;
  reg pid_en_q;
  reg timed_q;
  reg lim_en_q;
  reg [3:0] lim_q;
  reg [3:0] got_q;
  reg got_any_q;
  reg stop_q;
  reg [7:0] cnt_q;
  reg tmr_clr_q;
  reg [4:0] len_q;
  reg skip_q;
  reg [8:0] pos_q;
  reg pg2_msg_q;
  reg [4:0] first_q;
  reg [4:0] bs_q;
  reg [4:0] be_q;
  reg part_q;
  reg [2:0] ph_q;
  reg [4:0] ptr_q;
  reg fin_en_q;
  reg [2:0] fin_code_q;

  wire tick;
  wire hit1;
  wire hit2;
  wire slot = !o_out_valid || i_out_ready;
  wire [4:0] last = len_q - 5'h02;
  wire [7:0] pid_now = msg_q[pos_q[4:0]];
  wire [7:0] nxt = (pos_q < {4'h0, `BMRT_MSG_LAST}) ? msg_q[pos_q[4:0] + 5'h01] : 8'h00;
  wire [8:0] end_pos = pos_q + pid_len(pid_now, nxt);
  wire [4:0] end_clip = (end_pos > {4'h0, last}) ? last : end_pos[4:0];
  wire flt_on = i_first_pattern_filter_en || i_second_pattern_filter_en;
  wire flt_pass = !flt_on || hit1 || hit2;
  wire src_ok = (op_q != `BMRT_OP_MON_SRC) || (msg_q[0] == mid_q);
  wire rx_take = i_rx_valid && (state_q == S_COLLECT) && !skip_q;

  bmrt_tick #(.P_TICK_CYC(P_TICK_CYC)) u_tick (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(tmr_clr_q),
    .o_tick(tick)
  );

  bmrt_filter u_flt1 (
    .i_en(i_first_pattern_filter_en),
    .i_pat(i_first_pattern_filter),
    .i_care(i_first_pattern_care),
    .i_msg({msg_q[4], msg_q[3], msg_q[2], msg_q[1], msg_q[0]}),
    .i_nbytes(len_q - 5'h01),
    .o_hit(hit1)
  );

  bmrt_filter u_flt2 (
    .i_en(i_second_pattern_filter_en),
    .i_pat(i_second_pattern_filter),
    .i_care(i_second_pattern_care),
    .i_msg({msg_q[4], msg_q[3], msg_q[2], msg_q[1], msg_q[0]}),
    .i_nbytes(len_q - 5'h01),
    .o_hit(hit2)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Message store; bytes past the longest bus message are dropped
  always @(posedge i_clk) begin
    if (rx_take && (len_q < `BMRT_MSG_MAX)) begin
      msg_q[len_q] <= i_rx_data;
    end
  end

  // A message that starts while the previous one is being shown is skipped whole
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      skip_q <= 1'b0;
    end else if (i_rx_valid && i_rx_last) begin
      skip_q <= 1'b0;
    end else if (i_rx_valid && (state_q != S_COLLECT)) begin
      skip_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= S_IDLE;
      op_q <= `BMRT_OP_GET_MANY;
      mid_q <= 8'h00;
      pid_q <= 8'h00;
      pg2_req_q <= 1'b0;
      pid_en_q <= 1'b0;
      timed_q <= 1'b0;
      lim_en_q <= 1'b0;
      lim_q <= 4'h0;
      got_q <= 4'h0;
      got_any_q <= 1'b0;
      stop_q <= 1'b0;
      cnt_q <= `BMRT_ST_DEFAULT;
      tmr_clr_q <= 1'b0;
      len_q <= 5'h00;
      pos_q <= 9'h000;
      pg2_msg_q <= 1'b0;
      first_q <= 5'h01;
      bs_q <= 5'h01;
      be_q <= 5'h00;
      part_q <= 1'b0;
      ph_q <= PH_MID;
      ptr_q <= 5'h00;
      fin_en_q <= 1'b0;
      fin_code_q <= `BMRT_OUT_NODATA;
      o_out_valid <= 1'b0;
      o_out_data <= 8'h00;
      o_out_code <= `BMRT_OUT_BYTE;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      tmr_clr_q <= 1'b0;
      o_done <= 1'b0;
      if (i_out_ready) begin
        o_out_valid <= 1'b0;
      end
      // A character landing in the cycle stop_q is consumed is lost; the later clear wins
      if (i_host_char && (state_q != S_IDLE)) begin
        stop_q <= 1'b1;
      end
      // A tick issued before a reload must not shorten the new wait
      if (tick && !tmr_clr_q && (cnt_q != 8'h00)) begin
        cnt_q <= cnt_q - 8'h01;
      end
      case (state_q)
        S_IDLE: begin
          stop_q <= 1'b0;
          if (i_cmd_valid) begin
            op_q <= i_cmd_op;
            mid_q <= i_cmd_mid;
            pid_q <= i_cmd_pid[7:0];
            pg2_req_q <= i_cmd_pid[8];
            pid_en_q <= (i_cmd_op == `BMRT_OP_MON_PID) ||
                        ((i_cmd_op <= `BMRT_OP_GET_ONE) && i_cmd_pid_en);
            timed_q <= (i_cmd_op <= `BMRT_OP_GET_ONE);
            got_q <= 4'h0;
            got_any_q <= 1'b0;
            len_q <= 5'h00;
            cnt_q <= st_clamp(i_reply_timeout_setting);
            tmr_clr_q <= 1'b1;
            o_busy <= 1'b1;
            fin_en_q <= 1'b0;
            if (i_cmd_op == `BMRT_OP_GET_ONE) begin
              lim_en_q <= 1'b1;
              lim_q <= 4'h1;
              state_q <= S_COLLECT;
            end else if ((i_cmd_op == `BMRT_OP_GET_MANY) && i_cmd_raw && i_cmd_count_en) begin
              lim_en_q <= 1'b1;
              lim_q <= i_cmd_count;
              state_q <= (i_cmd_count == 4'h0) ? S_FINISH : S_COLLECT;
            end else begin
              lim_en_q <= 1'b0;
              lim_q <= 4'h0;
              state_q <= S_COLLECT;
            end
          end
        end
        S_COLLECT: begin
          if (stop_q) begin
            stop_q <= 1'b0;
            fin_en_q <= timed_q;
            fin_code_q <= `BMRT_OUT_STOP;
            state_q <= S_FINISH;
          end else if (timed_q && (cnt_q == 8'h00)) begin
            fin_en_q <= !got_any_q;
            fin_code_q <= `BMRT_OUT_NODATA;
            state_q <= S_FINISH;
          end else if (rx_take) begin
            if (len_q < `BMRT_MSG_MAX) begin
              len_q <= len_q + 5'h01;
            end
            if (i_rx_last) begin
              state_q <= S_CHECK;
            end
          end
        end
        S_CHECK: begin
          pg2_msg_q <= (msg_q[1] == `BMRT_PID_PAGE2);
          first_q <= (msg_q[1] == `BMRT_PID_PAGE2) ? 5'h02 : 5'h01;
          pos_q <= (msg_q[1] == `BMRT_PID_PAGE2) ? 9'h002 : 9'h001;
          bs_q <= 5'h01;
          be_q <= last;
          part_q <= 1'b0;
          ph_q <= PH_MID;
          if ((len_q < 5'h02) || !flt_pass || !src_ok) begin
            len_q <= 5'h00;
            state_q <= S_COLLECT;
          end else if (pid_en_q) begin
            state_q <= S_SCAN;
          end else begin
            state_q <= S_PRINT;
          end
        end
        S_SCAN: begin
          if (pos_q > {4'h0, last}) begin
            len_q <= 5'h00;
            state_q <= S_COLLECT;
          end else if ((pid_now == pid_q) && (pg2_msg_q == pg2_req_q)) begin
            bs_q <= pos_q[4:0];
            be_q <= end_clip;
            part_q <= (pos_q[4:0] != first_q) || (end_clip != last);
            ph_q <= PH_MID;
            state_q <= S_PRINT;
          end else begin
            pos_q <= end_pos + 9'h001;
          end
        end
        S_PRINT: begin
          if (slot) begin
            case (ph_q)
              PH_MID: begin
                if (!i_source_display_off) begin
                  o_out_valid <= 1'b1;
                  o_out_data <= msg_q[0];
                  o_out_code <= `BMRT_OUT_BYTE;
                end
                ptr_q <= bs_q;
                ph_q <= PH_HDR;
              end
              PH_HDR: begin
                if (pid_en_q && pg2_msg_q) begin
                  o_out_valid <= 1'b1;
                  o_out_data <= `BMRT_PID_PAGE2;
                  o_out_code <= `BMRT_OUT_BYTE;
                end
                ph_q <= PH_BODY;
              end
              PH_BODY: begin
                if (ptr_q <= be_q) begin
                  o_out_valid <= 1'b1;
                  o_out_data <= msg_q[ptr_q];
                  o_out_code <= `BMRT_OUT_BYTE;
                end
                if (ptr_q >= be_q) begin
                  ph_q <= PH_DASH;
                end else begin
                  ptr_q <= ptr_q + 5'h01;
                end
              end
              PH_DASH: begin
                if (i_checksum_display_on && part_q) begin
                  o_out_valid <= 1'b1;
                  o_out_data <= 8'h00;
                  o_out_code <= `BMRT_OUT_DASH;
                end
                ph_q <= PH_CSUM;
              end
              PH_CSUM: begin
                if (i_checksum_display_on) begin
                  o_out_valid <= 1'b1;
                  o_out_data <= msg_q[len_q - 5'h01];
                  o_out_code <= `BMRT_OUT_BYTE;
                end
                ph_q <= PH_EOL;
              end
              default: begin
                o_out_valid <= 1'b1;
                o_out_data <= 8'h00;
                o_out_code <= `BMRT_OUT_EOL;
                got_any_q <= 1'b1;
                len_q <= 5'h00;
                cnt_q <= st_clamp(i_reply_timeout_setting);
                tmr_clr_q <= 1'b1;
                if (lim_en_q) begin
                  got_q <= got_q + 4'h1;
                end
                if (lim_en_q && ((got_q + 4'h1) == lim_q)) begin
                  fin_en_q <= 1'b0;
                  state_q <= S_FINISH;
                end else begin
                  state_q <= S_COLLECT;
                end
              end
            endcase
          end
        end
        S_FINISH: begin
          if (slot) begin
            if (fin_en_q) begin
              o_out_valid <= 1'b1;
              o_out_data <= 8'h00;
              o_out_code <= fin_code_q;
            end
            o_busy <= 1'b0;
            o_done <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // bmrt_reply_timer

`default_nettype wire

/* bmrt_reply_timer_props.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bmrt_map.vh"
module bmrt_reply_timer_props #(
  parameter P_TICK_CYC = 20
) (
  input wire i_clk, // Clock
  input wire i_rst_n, // Reset, active low
  input wire i_cmd_valid, // Command strobe
  input wire [2:0] i_cmd_op, // Operation
  input wire [7:0] i_cmd_mid, // Source filter
  input wire i_cmd_raw, // Raw bytes given
  input wire i_cmd_count_en, // Count digit present
  input wire [3:0] i_cmd_count, // Count digit
  input wire [7:0] i_reply_timeout_setting, // Timeout units
  input wire i_source_display_off, // Hide source
  input wire i_checksum_display_on, // Show checksum
  input wire i_out_ready, // Item taken
  input wire o_out_valid, // Item valid
  input wire [7:0] o_out_data, // Item byte
  input wire [2:0] o_out_code, // Item kind
  input wire o_busy, // Busy
  input wire o_done // Done pulse
);
  wire start = i_cmd_valid && !o_busy;
  wire take = o_out_valid && i_out_ready;
  wire [31:0] lim = P_TICK_CYC * ((i_reply_timeout_setting == 8'h00) ? 8'h01 : i_reply_timeout_setting);
  reg [31:0] wait_q;
  reg [2:0] op_q;
  reg [7:0] mid_q;
  reg [4:0] lim_q;
  reg [3:0] eol_q;
  reg first_q;
  ////////////////////////////////////////////////////////////////
  // Timer reloads after each printed line
  always @(posedge i_clk) begin
    if (!i_rst_n || start) begin
      wait_q <= 32'h0;
      eol_q <= 4'h0;
      first_q <= 1'b1;
    end else begin
      wait_q <= o_out_valid ? 32'h0 : wait_q + 32'h1;
      if (take) begin
        first_q <= (o_out_code == `BMRT_OUT_EOL);
        if (o_out_code == `BMRT_OUT_EOL) eol_q <= eol_q + 4'h1;
      end
    end
    if (start) begin
      op_q <= i_cmd_op;
      mid_q <= i_cmd_mid;
      lim_q <= (i_cmd_op == `BMRT_OP_GET_ONE) ? 5'h11 :
        {i_cmd_op == `BMRT_OP_GET_MANY && i_cmd_raw && i_cmd_count_en, i_cmd_count};
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  busy_start_a: assert property (start |=> o_busy || o_done) else $error("busy not raised");
  done_end_a: assert property (o_done |-> !o_busy && $past(o_busy)) else $error("done without busy");
  done_pulse_a: assert property (o_done |=> !o_done) else $error("done longer than one cycle");
  item_hold_a: assert property (o_out_valid && !i_out_ready |=>
    o_out_valid && $stable(o_out_data) && $stable(o_out_code)) else $error("item dropped before taken");
  nodata_done_a: assert property ($rose(o_out_valid) && o_out_code == `BMRT_OUT_NODATA |-> o_done)
    else $error("empty result without done");
  wait_max_a: assert property (o_busy && op_q <= `BMRT_OP_GET_ONE |-> wait_q <= lim + 32'd4)
    else $error("reply wait too long");
  wait_min_a: assert property ($rose(o_out_valid) && o_out_code == `BMRT_OUT_NODATA |-> wait_q + 32'd3 >= lim)
    else $error("reply wait too short");
  count_stop_a: assert property (take && o_out_code == `BMRT_OUT_EOL && lim_q[4] && eol_q + 4'h1 == lim_q[3:0]
    |-> ##[1:3] o_done) else $error("no prompt return after count");
  src_first_a: assert property (o_out_valid && first_q && op_q == `BMRT_OP_MON_SRC && !i_source_display_off
    && o_out_code == `BMRT_OUT_BYTE |-> o_out_data == mid_q) else $error("wrong source printed");
  dash_off_a: assert property (o_out_valid && !i_checksum_display_on |-> o_out_code != `BMRT_OUT_DASH)
    else $error("dash with checksum hidden");
  dash_mode_a: assert property (o_out_valid && o_out_code == `BMRT_OUT_DASH |-> op_q == `BMRT_OP_MON_PID)
    else $error("dash outside parameter mode");
  nodata_c: cover property ($rose(o_out_valid) && o_out_code == `BMRT_OUT_NODATA);
  dash_c: cover property (take && o_out_code == `BMRT_OUT_DASH);
  count_c: cover property (take && o_out_code == `BMRT_OUT_EOL && lim_q[4] ##[1:3] o_done);
endmodule // bmrt_reply_timer_props
`default_nettype wire

/* bmrt_reply_timer_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bmrt_map.vh"
`define CHECK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module bmrt_reply_timer_tb;
  localparam int TICK = 20;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_cmd_valid = 1'b0, i_cmd_pid_en = 1'b0, i_cmd_raw = 1'b0;
  logic i_cmd_count_en = 1'b0, i_host_char = 1'b0, i_source_display_off = 1'b0, i_checksum_display_on = 1'b0;
  logic i_first_pattern_filter_en = 1'b0, i_second_pattern_filter_en = 1'b0, i_out_ready = 1'b1, stall = 1'b0;
  logic [2:0] i_cmd_op = 3'h0;
  logic [7:0] i_cmd_mid = 8'h00, i_reply_timeout_setting = 8'h01;
  logic [8:0] i_cmd_pid = 9'h000;
  logic [3:0] i_cmd_count = 4'h0;
  logic [39:0] i_first_pattern_filter = 40'h0, i_second_pattern_filter = 40'h0;
  logic [9:0] i_first_pattern_care = 10'h000, i_second_pattern_care = 10'h000;
  logic i_rx_valid, i_rx_last, o_out_valid, o_busy, o_done;
  logic [7:0] i_rx_data, o_out_data;
  logic [2:0] o_out_code;
  logic [10:0] out_q[$];
  int errors = 0;
  int tests_run = 0;
  int k;
  bmrt_reply_timer #(.P_TICK_CYC(TICK)) i_bmrt_reply_timer (.i_clk, .i_rst_n, .i_cmd_valid, .i_cmd_op, .i_cmd_mid,
    .i_cmd_pid, .i_cmd_pid_en, .i_cmd_raw, .i_cmd_count_en, .i_cmd_count, .i_host_char, .i_reply_timeout_setting,
    .i_source_display_off, .i_checksum_display_on, .i_first_pattern_filter_en, .i_first_pattern_filter,
    .i_first_pattern_care, .i_second_pattern_filter_en, .i_second_pattern_filter, .i_second_pattern_care,
    .i_rx_valid, .i_rx_data, .i_rx_last, .i_out_ready, .o_out_valid, .o_out_data, .o_out_code, .o_busy, .o_done);
  bmrt_bus_model i_bmrt_bus_model (.i_clk(i_clk), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data), .o_rx_last(i_rx_last));
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (o_out_valid && i_out_ready) out_q.push_back({o_out_code, o_out_code == `BMRT_OUT_BYTE ? o_out_data : 8'h00});
    if (stall) i_out_ready <= ~i_out_ready;
  end
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmd(input logic [2:0] op, input logic [8:0] pid, input logic [5:0] f);
    @(posedge i_clk);
    #1;
    i_cmd_op = op;
    i_cmd_pid = pid;
    i_cmd_pid_en = (pid != 9'h000);
    {i_cmd_raw, i_cmd_count_en, i_cmd_count} = f;
    i_cmd_valid = 1'b1;
    @(posedge i_clk);
    #1;
    i_cmd_valid = 1'b0;
  endtask
  task automatic wait_done(input int lim, output int n);
    n = 0;
    while (o_done !== 1'b1 && n < lim) begin
      @(negedge i_clk);
      n++;
    end
    if (n == lim) begin
      errors++;
      final_report();
    end
  endtask
  // Expected line: nb bytes, a dash before byte index dash, then the closing item
  task automatic expect_line(input logic [63:0] b, input int nb, input int dash, input logic [2:0] last);
    logic [10:0] got;
    int w;
    w = 0;
    while (out_q.size() < nb + 1 + (dash >= 0) && w < 300) begin
      @(posedge i_clk);
      w++;
    end
    if (w == 300) begin
      errors++;
      final_report();
    end
    for (int j = 0; j < nb; j++) begin
      if (j == dash) begin
        got = out_q.pop_front();
        `CHECK(got, {`BMRT_OUT_DASH, 8'h00})
      end
      got = out_q.pop_front();
      `CHECK(got, {`BMRT_OUT_BYTE, b[8*(nb-1-j) +: 8]})
    end
    got = out_q.pop_front();
    `CHECK(got, {last, 8'h00})
  endtask
  task automatic xfer(input logic [63:0] m, input int n, input logic [63:0] b, input int nb, input int dash);
    i_bmrt_bus_model.send(m, n);
    if (nb >= 0) expect_line(b, nb, dash, `BMRT_OUT_EOL);
  endtask
  task automatic stop_op();
    @(posedge i_clk);
    #1;
    i_host_char = 1'b1;
    @(posedge i_clk);
    #1;
    i_host_char = 1'b0;
    wait_done(40, k);
  endtask
  task automatic end_test(input string name);
    repeat (3) @(posedge i_clk);
    #1;
    `CHECK(out_q.size(), 0)
    $display("test %0s finished", name);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    for (int s = 1; s <= 15; s += 14) begin
      i_reply_timeout_setting = s[7:0];
      cmd(`BMRT_OP_GET_ONE, 9'h000, 6'h00);
      wait_done(400, k);
      `CHECK(k >= s * TICK && k <= s * TICK + 6, 1'b1)
      expect_line(64'h0, 0, -1, `BMRT_OUT_NODATA);
    end
    end_test("get_one_timeout");
    i_reply_timeout_setting = 8'h02;
    cmd(`BMRT_OP_GET_MANY, 9'h000, 6'h32);
    xfer(64'h805C66F2, 4, 64'h805C66, 3, -1);
    xfer(64'h81BE302FA3, 5, 64'h81BE302F, 4, -1);
    wait_done(5, k);
    cmd(`BMRT_OP_GET_MANY, 9'h05C, 6'h11);
    xfer(64'h805C66F2, 4, 64'h805C66, 3, -1);
    wait_done(3 * TICK, k);
    `CHECK(k >= 2 * TICK - 4, 1'b1)
    cmd(`BMRT_OP_GET_MANY, 9'h000, 6'h30);
    wait_done(4, k);
    cmd(`BMRT_OP_GET_MANY, 9'h000, 6'h00);
    stop_op();
    expect_line(64'h0, 0, -1, `BMRT_OUT_STOP);
    end_test("get_many_count");
    i_cmd_mid = 8'h80;
    cmd(`BMRT_OP_MON_SRC, 9'h000, 6'h00);
    xfer(64'h815C66F2, 4, 64'h0, -1, -1);
    xfer(64'h805C66BEE02EF2, 7, 64'h805C66BEE02E, 6, -1);
    repeat (3 * TICK) @(negedge i_clk);
    `CHECK(o_busy, 1'b1)
    stop_op();
    end_test("monitor_source");
    {i_source_display_off, i_checksum_display_on, stall} = 3'b111;
    cmd(`BMRT_OP_MON_ALL, 9'h000, 6'h00);
    xfer(64'h80B740065C64F2, 7, 64'hB740065C64F2, 6, -1);
    #1 stall = 1'b0;
    i_out_ready = 1'b1;
    stop_op();
    end_test("monitor_all");
    {i_source_display_off, i_checksum_display_on} = 2'b01;
    cmd(`BMRT_OP_MON_PID, 9'h0BE, 6'h00);
    xfer(64'h805C66BEE02EF2, 7, 64'h80BEE02EF2, 5, 4);
    xfer(64'h80BE302FA3, 5, 64'h80BE302FA3, 5, -1);
    stop_op();
    cmd(`BMRT_OP_MON_PID, 9'h170, 6'h00);
    xfer(64'h8070110F, 4, 64'h0, -1, -1);
    xfer(64'h80FF7011C0, 5, 64'h80FF7011C0, 5, -1);
    stop_op();
    end_test("monitor_parameter");
    {i_source_display_off, i_checksum_display_on} = 2'b00;
    {i_first_pattern_filter_en, i_second_pattern_filter_en} = 2'b11;
    i_first_pattern_filter = 40'h0000000080;
    i_first_pattern_care = 10'h003;
    i_second_pattern_filter = 40'h0000005C00;
    i_second_pattern_care = 10'h00C;
    cmd(`BMRT_OP_MON_ALL, 9'h000, 6'h00);
    xfer(64'h810A01F2, 4, 64'h0, -1, -1);
    xfer(64'h815C66F2, 4, 64'h815C66, 3, -1);
    xfer(64'h800A01F2, 4, 64'h800A01, 3, -1);
    stop_op();
    end_test("pattern_filters");
    final_report();
  end
endmodule // bmrt_reply_timer_tb
bind bmrt_reply_timer bmrt_reply_timer_props #(.P_TICK_CYC(P_TICK_CYC)) i_bmrt_reply_timer_props (.i_clk, .i_rst_n,
  .i_cmd_valid, .i_cmd_op, .i_cmd_mid, .i_cmd_raw, .i_cmd_count_en, .i_cmd_count, .i_reply_timeout_setting,
  .i_source_display_off, .i_checksum_display_on, .i_out_ready, .o_out_valid, .o_out_data, .o_out_code,
  .o_busy, .o_done);
`default_nettype wire

/* bmrt_tick.v */
`timescale 1ns/1ns
`default_nettype none
`include "bmrt_map.vh"

module bmrt_tick #(
  parameter P_TICK_CYC = `BMRT_TICK_CYC
) (
  input wire i_clk,     // System clock
  input wire i_rst_n,   // Synchronous reset, active low
  input wire i_clear,   // Restart the tick period
  output reg o_tick     // One-cycle pulse every tick period
);

  reg [`BMRT_TICK_W-1:0] div_q;

  always @(posedge i_clk) begin
    if (!i_rst_n || i_clear) begin
      div_q <= {`BMRT_TICK_W{1'b0}};
      o_tick <= 1'b0;
    end else if ({8'h00, div_q} == P_TICK_CYC - 1) begin
      div_q <= {`BMRT_TICK_W{1'b0}};
      o_tick <= 1'b1;
    end else begin
      div_q <= div_q + 24'h000001;
      o_tick <= 1'b0;
    end
  end

endmodule // bmrt_tick

`default_nettype wire
